// [verilog/csq_params.svh]
// constants for the compressor and sequencer output block
`ifndef CSQ_PARAMS_SVH
`define CSQ_PARAMS_SVH
// ==================================================
// timing
`define CSQ_CLK_NS 10
`define CSQ_SEC_NS 1000000000
`define CSQ_SEC_CYCLES (`CSQ_SEC_NS / `CSQ_CLK_NS)
`define CSQ_TMAX 14'h3fff
// ==================================================
// register offsets (byte addresses, low address byte)
`define CSQ_REG_CTRL 8'h00
`define CSQ_REG_A_ON 8'h04
`define CSQ_REG_A_OFF 8'h08
`define CSQ_REG_B_ON 8'h0c
`define CSQ_REG_B_OFF 8'h10
`define CSQ_REG_MIN_ON 8'h14
`define CSQ_REG_MIN_OFF 8'h18
`define CSQ_REG_OFF_DLY 8'h1c
`define CSQ_REG_IDLE_DLY 8'h20
`define CSQ_REG_SIZE1 8'h24
`define CSQ_REG_SIZE2 8'h28
`define CSQ_REG_SIZE3 8'h2c
`define CSQ_REG_SIZE4 8'h30
`define CSQ_REG_SEQ_DLY 8'h34
`define CSQ_REG_STATUS 8'h38
// ==================================================
// fields and reset values
`define CSQ_CTRL_FN_MSB 1
`define CSQ_CTRL_BCONN 2
`define CSQ_RST_CTRL 3'h0
`define CSQ_RST_PCT 16'h0000
`define CSQ_RST_TIME 14'h0000
`define CSQ_RST_SIZE 17'h00000
// full scale of a percentage in tenths, and its product width form
`define CSQ_PCT_FULL 16'h03e8
`define CSQ_KILO 30'h3e8
`endif

// [verilog/csq_pkg.sv]
// types for the compressor and sequencer output block
package csq_pkg;
  // selectable output function
  typedef enum logic [1:0] {
    CSQ_FN_OFF = 2'h0,
    CSQ_FN_COMP = 2'h1,
    CSQ_FN_SEQ = 2'h2
  } csq_func_t;
  // compressor states, one-hot
  typedef enum logic [1:0] {
    CSQ_ST_IDLE = 2'h1,
    CSQ_ST_RUN = 2'h2
  } csq_cst_t;
endpackage

// [verilog/csq_div.sv]
// iterative restoring divider for the vernier share
`timescale 1ns/1ps
module csq_div (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [29:0] num,
  input wire logic [16:0] den,
  output logic busy,
  output logic done,
  output logic [10:0] quo
);
  logic [30:0] rem_r;
  logic [29:0] q_r;
  logic [4:0] cnt_r;
  logic [16:0] den_r;
  wire [30:0] trial = {rem_r[29:0], q_r[29]};
  wire fits = trial >= {14'h0000, den_r};
  wire [29:0] q_nxt = {q_r[28:0], fits};

  // ==================================================
  // one quotient bit per cycle; caller keeps the quotient below 1001
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rem_r <= 31'h00000000;
      q_r <= 30'h00000000;
      cnt_r <= 5'h00;
      den_r <= 17'h00000;
      busy <= 1'b0;
      done <= 1'b0;
      quo <= 11'h000;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        rem_r <= 31'h00000000;
        q_r <= num;
        den_r <= den;
        cnt_r <= 5'h1e;
        busy <= 1'b1;
      end else if (busy) begin
        rem_r <= fits ? trial - {14'h0000, den_r} : trial;
        q_r <= q_nxt;
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quo <= q_nxt[10:0];
        end
      end
    end
  end
endmodule

// [verilog/csq_top.sv]
// compressor control and power sequencer output with ahb-lite registers
// Behaviour
// - input a at or below its turn-on level plus off time met starts compressor
// - input b at or below its own turn-on level plus off time starts compressor
// - input a at or above turn-off means no demand; drop waits for on time
// - input b at or above turn-off means no demand; drop waits for on time
// - compressor stays on at least the minimum on time in seconds
// - compressor stays off at least the minimum off time before restarting
// - after on time and no demand, hold on for the off delay then stop
// - any demand during off delay keeps compressor on and clears the delay
// - loop demands at exactly zero longer than idle delay stop the compressor
// - idle delay of zero disables the zero-power stop
// - compressor function drives one run output from two percentage demands
// - sequencer splits one 0-100% demand into vernier plus three on/off outputs
// - each sequencer output has a share from 0 to 99999; the size registers take any 17-bit value, up to 131071
// - at least the sequencer delay passes between successive on/off turn-ons
// - function off passes input to output one, other outputs inactive
// - linear order always switches on/off outputs in order two, three, four
`timescale 1ns/1ps
`include "csq_params.svh"
module csq_top #(
  parameter int SEC_CYCLES = `CSQ_SEC_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic signed [15:0] dmd_a,
  input wire logic signed [15:0] dmd_b,
  output logic signed [15:0] pct_out,
  output logic comp_run,
  output logic [2:0] onoff_out
);
  // ==================================================
  // register bus: zero wait states, always okay
  logic wr_pend_r;
  logic [7:0] wa_r;
  logic [2:0] ctrl_r;
  logic signed [15:0] a_on_r, a_off_r, b_on_r, b_off_r;
  logic [13:0] min_on_r, min_off_r, odly_r, idly_r, sdly_r;
  logic [16:0] size_r [4];
  logic [31:0] rd_mux;
  csq_pkg::csq_cst_t cst_r;
  csq_pkg::csq_cst_t cst_nxt;

  wire ahb_go = hsel & hready & htrans[1];
  wire [7:0] ra = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // read select; unmapped offsets read zero
  assign rd_mux =
    (ra == `CSQ_REG_CTRL) ? {29'h0, ctrl_r} :
    (ra == `CSQ_REG_A_ON) ? {{16{a_on_r[15]}}, a_on_r} :
    (ra == `CSQ_REG_A_OFF) ? {{16{a_off_r[15]}}, a_off_r} :
    (ra == `CSQ_REG_B_ON) ? {{16{b_on_r[15]}}, b_on_r} :
    (ra == `CSQ_REG_B_OFF) ? {{16{b_off_r[15]}}, b_off_r} :
    (ra == `CSQ_REG_MIN_ON) ? {18'h0, min_on_r} :
    (ra == `CSQ_REG_MIN_OFF) ? {18'h0, min_off_r} :
    (ra == `CSQ_REG_OFF_DLY) ? {18'h0, odly_r} :
    (ra == `CSQ_REG_IDLE_DLY) ? {18'h0, idly_r} :
    (ra == `CSQ_REG_SIZE1) ? {15'h0, size_r[0]} :
    (ra == `CSQ_REG_SIZE2) ? {15'h0, size_r[1]} :
    (ra == `CSQ_REG_SIZE3) ? {15'h0, size_r[2]} :
    (ra == `CSQ_REG_SIZE4) ? {15'h0, size_r[3]} :
    (ra == `CSQ_REG_SEQ_DLY) ? {18'h0, sdly_r} :
    (ra == `CSQ_REG_STATUS) ? {10'h0, cst_r, comp_run, onoff_out, pct_out} : 32'h0;

  // address phase capture; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend_r <= ahb_go & hwrite;
      if (ahb_go) wa_r <= ra;
      hrdata <= (ahb_go & ~hwrite) ? rd_mux : 32'h0;
    end
  end

  // write data phase; writes to unmapped or status offsets are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CSQ_RST_CTRL;
      a_on_r <= `CSQ_RST_PCT;
      a_off_r <= `CSQ_RST_PCT;
      b_on_r <= `CSQ_RST_PCT;
      b_off_r <= `CSQ_RST_PCT;
      min_on_r <= `CSQ_RST_TIME;
      min_off_r <= `CSQ_RST_TIME;
      odly_r <= `CSQ_RST_TIME;
      idly_r <= `CSQ_RST_TIME;
      sdly_r <= `CSQ_RST_TIME;
      for (int i = 0; i < 4; i++) size_r[i] <= `CSQ_RST_SIZE;
    end else if (wr_pend_r) begin
      unique case (wa_r)
        `CSQ_REG_CTRL: ctrl_r <= hwdata[2:0];
        `CSQ_REG_A_ON: a_on_r <= hwdata[15:0];
        `CSQ_REG_A_OFF: a_off_r <= hwdata[15:0];
        `CSQ_REG_B_ON: b_on_r <= hwdata[15:0];
        `CSQ_REG_B_OFF: b_off_r <= hwdata[15:0];
        `CSQ_REG_MIN_ON: min_on_r <= hwdata[13:0];
        `CSQ_REG_MIN_OFF: min_off_r <= hwdata[13:0];
        `CSQ_REG_OFF_DLY: odly_r <= hwdata[13:0];
        `CSQ_REG_IDLE_DLY: idly_r <= hwdata[13:0];
        `CSQ_REG_SIZE1: size_r[0] <= hwdata[16:0];
        `CSQ_REG_SIZE2: size_r[1] <= hwdata[16:0];
        `CSQ_REG_SIZE3: size_r[2] <= hwdata[16:0];
        `CSQ_REG_SIZE4: size_r[3] <= hwdata[16:0];
        `CSQ_REG_SEQ_DLY: sdly_r <= hwdata[13:0];
        default: ;
      endcase
    end
  end

  wire fn_comp = ctrl_r[`CSQ_CTRL_FN_MSB:0] == csq_pkg::CSQ_FN_COMP;
  wire fn_seq = ctrl_r[`CSQ_CTRL_FN_MSB:0] == csq_pkg::CSQ_FN_SEQ;
  wire b_conn = ctrl_r[`CSQ_CTRL_BCONN];

  // ==================================================
  // one-second tick
  logic [31:0] div_r;
  wire tick = div_r == 32'(SEC_CYCLES - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_r <= 32'h0;
    else div_r <= tick ? 32'h0 : div_r + 32'h1;
  end

  // saturating second count
  function automatic logic [13:0] sat_inc(input logic [13:0] c, input logic t);
    sat_inc = (t && c != `CSQ_TMAX) ? c + 14'h0001 : c;
  endfunction

  // ==================================================
  // compressor demand decode
  logic [13:0] on_cnt, off_cnt, odly_cnt, idle_cnt;
  wire want_a = dmd_a <= a_on_r;
  // demand from b, only when b is connected
  wire want_b = b_conn && (dmd_b <= b_on_r);
  wire nod_a = dmd_a >= a_off_r;
  // no demand from b; an unconnected b never asks
  wire nod_b = !b_conn || (dmd_b >= b_off_r);
  wire nodmd = nod_a & nod_b;
  // every connected loop at exactly zero
  wire zero_all = (dmd_a == 16'sh0000) && (!b_conn || dmd_b == 16'sh0000);
  // zero delay turns the idle stop off
  wire idle_hit = (idly_r != 14'h0) && (idle_cnt > idly_r);
  // counts run from a mid-second start, so the strict compare keeps the full minimum
  wire ok_on = (min_on_r == 14'h0) || (on_cnt > min_on_r);
  wire ok_off = (min_off_r == 14'h0) || (off_cnt > min_off_r);
  wire odly_ok = (odly_r == 14'h0) || (odly_cnt > odly_r);
  wire running = cst_r == csq_pkg::CSQ_ST_RUN;
  // turn-on gated by the off time; idle stop blocks an instant restart
  wire go_on = fn_comp && !running && ok_off && (want_a || want_b) && !idle_hit;
  // turn-off waits for on time, then off delay or idle stop
  wire go_off = running && ok_on && ((nodmd && odly_ok) || idle_hit);

  // next compressor state; any other function parks it off
  always_comb begin
    cst_nxt = cst_r;
    if (!fn_comp) cst_nxt = csq_pkg::CSQ_ST_IDLE;
    else if (go_on) cst_nxt = csq_pkg::CSQ_ST_RUN;
    else if (go_off) cst_nxt = csq_pkg::CSQ_ST_IDLE;
  end

  // timers clear on reset with the compressor off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cst_r <= csq_pkg::CSQ_ST_IDLE;
      on_cnt <= 14'h0;
      off_cnt <= 14'h0;
      odly_cnt <= 14'h0;
      idle_cnt <= 14'h0;
    end else begin
      cst_r <= cst_nxt;
      on_cnt <= go_on ? 14'h0 : sat_inc(on_cnt, tick & running);
      off_cnt <= (running && cst_nxt != csq_pkg::CSQ_ST_RUN) ? 14'h0 : sat_inc(off_cnt, tick & !running);
      // any demand during the delay clears it
      odly_cnt <= (running && ok_on && nodmd) ? sat_inc(odly_cnt, tick) : 14'h0;
      idle_cnt <= zero_all ? sat_inc(idle_cnt, tick) : 14'h0;
    end
  end

  assign comp_run = running;

  // ==================================================
  // sequencer shares
  wire [9:0] dmd_c = dmd_a[15] ? 10'h000 : (dmd_a > $signed(`CSQ_PCT_FULL)) ? 10'h3e8 : dmd_a[9:0];
  wire [18:0] tot = 19'(size_r[0]) + 19'(size_r[1]) + 19'(size_r[2]) + 19'(size_r[3]);
  // demand scaled to share units, times the full scale
  wire [29:0] p_dem = 30'(dmd_c) * 30'(tot);
  logic [2:0] on_r, keep, onoff_nxt;
  logic [13:0] seq_cnt;
  logic [18:0] cum [3];
  logic [18:0] onsz [3];
  genvar k;
  // per on/off output: cumulative share, target and share held on
  generate
    for (k = 0; k < 3; k++) begin : g_out
      if (k == 0) begin : g_first
        assign cum[k] = 19'(size_r[1]);
        assign keep[k] = (size_r[1] != 17'h0) && (p_dem >= `CSQ_KILO * 30'(cum[k]));
      end else begin : g_next
        assign cum[k] = cum[k-1] + 19'(size_r[k+1]);
        assign keep[k] = keep[k-1] && (size_r[k+1] != 17'h0) && (p_dem >= `CSQ_KILO * 30'(cum[k]));
      end
      assign onsz[k] = on_r[k] ? 19'(size_r[k+1]) : 19'h0;
    end
  endgenerate

  // linear order, next output is the lowest one still off
  wire [2:0] next_bit = ~on_r & {on_r[1:0], 1'b1};
  wire seq_ok = (sdly_r == 14'h0) || (seq_cnt > sdly_r);
  wire add_ok = fn_seq && seq_ok && ((next_bit & keep) != 3'h0);
  // drop at once when demand falls, add one at a time
  assign onoff_nxt = fn_seq ? ((on_r & keep) | (add_ok ? next_bit : 3'h0)) : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_r <= 3'h0;
      seq_cnt <= `CSQ_TMAX;
    end else begin
      on_r <= onoff_nxt;
      seq_cnt <= add_ok ? 14'h0 : sat_inc(seq_cnt, tick);
    end
  end
  assign onoff_out = on_r;

  // ==================================================
  // vernier: remainder over its own share, clamped into 0..full
  wire [18:0] on_sum = onsz[0] + onsz[1] + onsz[2];
  wire [29:0] on_k = `CSQ_KILO * 30'(on_sum);
  wire [29:0] v_max = `CSQ_KILO * 30'(size_r[0]);
  wire [29:0] rem_raw = (p_dem > on_k) ? p_dem - on_k : 30'h0;
  wire [29:0] v_num = (rem_raw > v_max) ? v_max : rem_raw;
  // zero share would divide by zero; a share of one with a zero numerator gives zero
  wire [16:0] v_den = (size_r[0] == 17'h0) ? 17'h00001 : size_r[0];
  wire div_busy, div_done;
  wire [10:0] v_quo;

  csq_div csq_div_i (
    .clk(hclk),
    .rstn(hresetn),
    .start(fn_seq),
    .num(v_num),
    .den(v_den),
    .busy(div_busy),
    .done(div_done),
    .quo(v_quo)
  );

  // function off passes input a straight through
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pct_out <= `CSQ_RST_PCT;
    else if (fn_seq) begin
      if (div_done) pct_out <= {5'h00, v_quo};
    end else if (fn_comp) pct_out <= `CSQ_RST_PCT;
    else pct_out <= dmd_a;
  end

  // ==================================================
  // checks
  comp_min_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(comp_run) && $past(fn_comp) |-> ($past(on_cnt) > $past(min_on_r)) || ($past(min_on_r) == 14'h0))
    else $error("compressor dropped before minimum on time");
  comp_min_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(comp_run) |-> ($past(off_cnt) > $past(min_off_r)) || ($past(min_off_r) == 14'h0))
    else $error("compressor restarted before minimum off time");
  comp_on_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(comp_run) |-> $past(want_a) || $past(want_b))
    else $error("compressor started without demand");
  comp_off_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(comp_run) && $past(fn_comp) && !$past(idle_hit) |-> $past(nodmd) && $past(odly_ok))
    else $error("compressor stopped before off delay");
  delay_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    running && !nodmd |=> odly_cnt == 14'h0)
    else $error("off delay not cleared by demand");
  idle_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fn_comp && running && idly_r == 14'h0 && zero_all && !nodmd |=> comp_run)
    else $error("idle stop active while disabled");
  pass_through_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !fn_seq && !fn_comp |=> pct_out == $past(dmd_a) && onoff_out == 3'h0)
    else $error("off function not passing input");
  seq_space_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (onoff_out & ~$past(onoff_out)) != 3'h0 |-> ($past(seq_cnt) > sdly_r) || (sdly_r == 14'h0) || $changed(sdly_r))
    else $error("on/off outputs switched on too close together");
  seq_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    onoff_out == 3'h0 || onoff_out == 3'h1 || onoff_out == 3'h3 || onoff_out == 3'h7)
    else $error("on/off outputs out of linear order");
  vern_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fn_seq && $past(fn_seq) && !$rose(fn_seq) |-> pct_out <= $signed(`CSQ_PCT_FULL) && !pct_out[15])
    else $error("vernier output outside 0 to 100 percent");
endmodule

// [testbench/csq_loops.sv]
// behavioural model of the two control loops that feed the demand inputs
`timescale 1ns/1ps
module csq_loops (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic signed [15:0] tgt_a,
  input wire logic signed [15:0] tgt_b,
  output logic signed [15:0] dmd_a,
  output logic signed [15:0] dmd_b
);
  // ==================================================
  // output limiting
  // a loop never drives its power beyond -100.0..100.0 percent (tenths)
  function automatic logic signed [15:0] lim(input logic signed [15:0] v);
    if (v > 16'sh03e8) return 16'sh03e8;
    if (v < -16'sh03e8) return -16'sh03e8;
    return v;
  endfunction
  // ==================================================
  // loop outputs
  // registered like a real loop update, so demand steps arrive one cycle late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dmd_a <= 16'sh0000; // loops start at zero power
      dmd_b <= 16'sh0000;
    end else begin
      dmd_a <= lim(tgt_a);
      dmd_b <= lim(tgt_b);
    end
  end
endmodule

// [testbench/csq_top_bench.sv]
// self-checking bench for the compressor and sequencer output block
`timescale 1ns/1ps
`include "csq_params.svh"
module csq_top_bench;
  // ==================================================
  // signals and instances
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic comp_run;
  logic [2:0] onoff_out;
  logic signed [15:0] pct_out, dmd_a, dmd_b;
  logic signed [15:0] tgt_a = 16'sh0000;
  logic signed [15:0] tgt_b = 16'sh0000;
  int fails = 0;
  int n_tests = 0;
  // short second so the timers finish in tens of cycles
  csq_top #(.SEC_CYCLES(10)) csq_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dmd_a(dmd_a), .dmd_b(dmd_b), .pct_out(pct_out),
    .comp_run(comp_run), .onoff_out(onoff_out));
  csq_loops csq_loops_i (.hclk(hclk), .hresetn(hresetn), .tgt_a(tgt_a), .tgt_b(tgt_b), .dmd_a(dmd_a),
    .dmd_b(dmd_b));
  always #5 hclk = ~hclk;
  // ==================================================
  // checks and verdict
  task automatic print_verdict;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] cur(input int w);
    if (w == 0) return {15'h0, comp_run};
    if (w == 1) return {13'h0, onoff_out};
    return pct_out;
  endfunction
  // sampled at falling edges so the design's updates have landed; ends on a rising edge
  task automatic wv(input int w, input logic [15:0] e, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    @(negedge hclk);
    while (cur(w) !== e && n <= hi) begin
      @(negedge hclk);
      n++;
    end
    @(posedge hclk);
    n_tests++;
    if (n < lo || n > hi) begin
      fails++;
      $display("mismatch %s expected %h within %0d..%0d seen after %0d", nm, e, lo, hi, n);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // ==================================================
  // ahb-lite master, single word transfers
  task automatic rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    rdy();
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge hclk);
    // idle cycle before the next transfer; the write has already landed at the data phase edge
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // ==================================================
  // watchdog at 30000 cycles, far beyond the thousand or so cycles the tests need
  initial begin
    #300000;
    fails++;
    print_verdict();
  end
  // ==================================================
  // test sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 64; a += 4) rdc(8'(a), (8'(a) == `CSQ_REG_STATUS) ? 32'h00100000 : 32'h0);
    wr(8'h3c, 32'hffffffff);
    rdc(8'h3c, 32'h0);
    wr(`CSQ_REG_STATUS, 32'hffffffff);
    rdc(`CSQ_REG_STATUS, 32'h00100000);
    // compressor from input a alone
    wr(`CSQ_REG_A_ON, 32'hffffffec);
    rdc(`CSQ_REG_A_ON, 32'hffffffec);
    wr(`CSQ_REG_A_OFF, 32'h14);
    wr(`CSQ_REG_MIN_ON, 32'h3);
    wr(`CSQ_REG_MIN_OFF, 32'h2);
    wr(`CSQ_REG_OFF_DLY, 32'h2);
    wr(`CSQ_REG_CTRL, {30'h0, csq_pkg::CSQ_FN_COMP});
    tgt_a <= 16'shffec;
    wv(0, 16'h1, 0, 35, "run at a turn-on");
    tgt_a <= 16'sh0014;
    wv(0, 16'h0, 48, 75, "on time then off delay");
    tgt_a <= 16'shff9c;
    wv(0, 16'h1, 18, 35, "minimum off");
    tgt_a <= 16'sh0014;
    cyc(45);
    tgt_a <= 16'sh0013;
    cyc(10);
    wv(0, 16'h1, 0, 0, "held by demand");
    tgt_a <= 16'sh0014;
    wv(0, 16'h0, 18, 35, "off delay restarted");
    // compressor from input b, a idle above its turn-off
    wr(`CSQ_REG_B_ON, 32'hffffffce);
    wr(`CSQ_REG_B_OFF, 32'h32);
    tgt_a <= 16'sh01f4;
    wr(`CSQ_REG_CTRL, {29'h0, 1'b1, csq_pkg::CSQ_FN_COMP});
    tgt_b <= 16'shffce;
    wv(0, 16'h1, 0, 35, "run at b turn-on");
    tgt_b <= 16'sh0032;
    wv(0, 16'h0, 48, 75, "b turn-off");
    // zero power stop, then disabled
    wr(`CSQ_REG_IDLE_DLY, 32'h2);
    wr(`CSQ_REG_OFF_DLY, 32'h14);
    tgt_a <= 16'shffec;
    wv(0, 16'h1, 0, 35, "idle run");
    tgt_a <= 16'sh0000;
    tgt_b <= 16'sh0000;
    wv(0, 16'h0, 28, 45, "idle stop");
    wr(`CSQ_REG_IDLE_DLY, 32'h0);
    tgt_a <= 16'shffec;
    wv(0, 16'h1, 0, 35, "run again");
    tgt_a <= 16'sh0000;
    cyc(80);
    wv(0, 16'h1, 0, 0, "idle stop disabled");
    wr(`CSQ_REG_OFF_DLY, 32'h0);
    tgt_a <= 16'sh01f4;
    tgt_b <= 16'sh01f4;
    wv(0, 16'h0, 0, 10, "released");
    // sequencer, vernier share above each on/off share
    wr(`CSQ_REG_SIZE1, 32'hfa0);
    for (int k = 0; k < 3; k++) wr(`CSQ_REG_SIZE2 + 8'(4 * k), 32'h7d0);
    wr(`CSQ_REG_SEQ_DLY, 32'h2);
    tgt_a <= 16'sh03e8;
    wr(`CSQ_REG_CTRL, {30'h0, csq_pkg::CSQ_FN_SEQ});
    wv(1, 16'h1, 0, 10, "first stage");
    wv(1, 16'h3, 18, 35, "second stage");
    wv(1, 16'h7, 18, 35, "third stage");
    wv(2, 16'h03e8, 0, 80, "vernier full");
    wv(0, 16'h0, 0, 0, "no run in sequencer");
    tgt_a <= 16'sh01f4;
    wv(1, 16'h3, 0, 5, "stage dropped");
    wv(2, 16'h00fa, 0, 80, "vernier remainder");
    tgt_a <= 16'shffce;
    wv(1, 16'h0, 0, 5, "all stages off");
    wv(2, 16'h0000, 0, 80, "vernier clamped");
    tgt_a <= 16'sh03e8;
    // first stage at once, then two full spacings of three ticks each
    wv(1, 16'h7, 50, 70, "restaged");
    // reset in mid-run clears outputs, then function off passes input through
    hresetn <= 1'b0;
    wv(1, 16'h0, 0, 0, "stages in reset");
    wv(2, 16'h0000, 0, 0, "vernier in reset");
    hresetn <= 1'b1;
    tgt_a <= 16'shff85;
    wv(2, 16'hff85, 0, 3, "pass through");
    wv(1, 16'h0, 0, 0, "others inactive");
    rdc(`CSQ_REG_STATUS, 32'h0010ff85);
    // function code three is treated as off, so nothing may change
    wr(`CSQ_REG_CTRL, 32'h3);
    cyc(40);
    rdc(`CSQ_REG_STATUS, 32'h0010ff85);
    print_verdict();
  end
endmodule
